// ===== common/srs_pkg.sv
// Package for the standby and remote selection block.
// Assumes a single 25 MHz clock and profile settings held outside as plain ports.
package srs_pkg;
    // ----------------------------------------
    // Sizes
    // ----------------------------------------
    localparam int NUM_MODES = 8;
    localparam int NUM_PROFILES = 8;
    localparam int MODE_W = 3;
    localparam int PROF_W = 3;
    localparam int TIME_W = 8;
    // ----------------------------------------
    // Timing
    // ----------------------------------------
    localparam int CLK_HZ = 25000000;
    localparam int SECOND_NS = 1000000000;
    localparam int CLK_PERIOD_NS = SECOND_NS / CLK_HZ;
    localparam int TICK_CYCLES = SECOND_NS / CLK_PERIOD_NS;
    localparam logic [TIME_W-1:0] MAX_STANDBY_S = 8'hc8;
    // ----------------------------------------
    // Reset values
    // ----------------------------------------
    localparam logic [MODE_W-1:0] RST_MODE = 3'h0;
    localparam logic [PROF_W-1:0] RST_PROFILE = 3'h0;

    typedef enum logic [1:0] {
        SRS_RUN = 2'b00,
        SRS_STANDBY = 2'b01,
        SRS_REMOTE = 2'b11
    } srs_state_type;

    // Joystick deflection flags, one-cycle pulses on the rising edge of each direction pin
    typedef struct packed {
        logic fwd;
        logic rev;
        logic left;
        logic right;
    } srs_dir_type;

    // Per-profile settings
    typedef struct packed {
        logic [NUM_MODES-1:0] standby_in_mode;
        logic [TIME_W-1:0] standby_inactivity_time;
        logic external_switch_standby_enable;
        logic standby_direction_pick_enable;
        logic remote_pick_enable;
        logic [MODE_W-1:0] target_fwd;
        logic [MODE_W-1:0] target_rev;
        logic [MODE_W-1:0] target_left;
        logic [MODE_W-1:0] target_right;
    } srs_prof_cfg_type;
endpackage

// ===== verilog/srs_sync.sv
// Two-flop synchroniser bank for pin inputs.
// Assumes inputs are asynchronous levels.
module srs_sync #(
    parameter int WIDTH = 8
) (
    // Clock and reset
    input wire logic i_clk,
    input wire logic i_rstn,
    input wire logic i_ce,
    // Data
    input wire logic [WIDTH-1:0] i_async,
    output logic [WIDTH-1:0] o_sync
);
    logic [WIDTH-1:0] meta_q;
    logic [WIDTH-1:0] sync_q;

    always_ff @(posedge i_clk or negedge i_rstn)
    begin
        if (!i_rstn)
        begin
            // Ones, so a rising-edge detector behind this sees no edge from a pin held
            meta_q <= '1;
            sync_q <= '1;
        end
        else if (i_ce)
        begin
            meta_q <= i_async;
            sync_q <= meta_q;
        end
    end

    assign o_sync = sync_q;
endmodule // srs_sync

// ===== verilog/srs_top.sv
// Standby and remote profile selection for a joystick control system.
// Assumes joystick, buttons and profile switch are asynchronous pins; settings are static.
// ----------------------------------------
// ----------------------------------------
module srs_top #(
    parameter int TICK = srs_pkg::TICK_CYCLES
) (
    // Clock and reset
    input wire logic i_clk,
    input wire logic i_rstn,
    input wire logic i_ce,
    // Pins
    input wire logic i_js_fwd,
    input wire logic i_js_rev,
    input wire logic i_js_left,
    input wire logic i_js_right,
    input wire logic i_js_neutral,
    input wire logic i_mode_button,
    input wire logic i_profile_button,
    input wire logic i_ext_switch,
    // Settings
    input wire srs_pkg::srs_prof_cfg_type i_cfg [srs_pkg::NUM_PROFILES],
    // Status
    output logic [srs_pkg::MODE_W-1:0] o_mode,
    output logic [srs_pkg::PROF_W-1:0] o_profile,
    output logic o_standby,
    output logic o_remote,
    output logic [srs_pkg::PROF_W-1:0] o_highlight
);
    localparam int NP = srs_pkg::NUM_PROFILES;
    localparam int PW = srs_pkg::PROF_W;
    localparam int MW = srs_pkg::MODE_W;
    localparam int TW = srs_pkg::TIME_W;
    localparam int CW = $clog2(TICK + 1);

    // ----------------------------------------
    // Input synchronisation and edges
    // ----------------------------------------
    logic [7:0] pins_s;
    logic [7:0] pins_prev_q;
    logic [7:0] rise;

    srs_sync #(.WIDTH(8)) u_sync (
        .i_clk(i_clk),
        .i_rstn(i_rstn),
        .i_ce(i_ce),
        .i_async({i_js_fwd, i_js_rev, i_js_left, i_js_right, i_js_neutral,
                  i_mode_button, i_profile_button, i_ext_switch}),
        .o_sync(pins_s)
    );

    always_ff @(posedge i_clk or negedge i_rstn)
    begin
        if (!i_rstn)
            pins_prev_q <= 8'hff;
        else if (i_ce)
            pins_prev_q <= pins_s;
    end

    assign rise = pins_s & ~pins_prev_q;

    srs_pkg::srs_dir_type dir;
    wire neutral = pins_s[3];
    wire mode_btn = rise[2];
    wire prof_btn = rise[1];
    wire ext_sw = rise[0];
    assign dir = '{fwd: rise[7], rev: rise[6], left: rise[5], right: rise[4]};
    wire any_dir = dir.fwd | dir.rev | dir.left | dir.right;

    // ----------------------------------------
    // State
    // ----------------------------------------
    srs_pkg::srs_state_type state_q, state_d;
    logic [MW-1:0] mode_q, mode_d;
    logic [PW-1:0] prof_q, prof_d;
    logic [PW-1:0] hl_q, hl_d;
    logic [CW-1:0] tick_q;
    logic [TW-1:0] sec_q;

    srs_pkg::srs_prof_cfg_type cfg;
    assign cfg = i_cfg[prof_q];

    // Next profile with remote picking on, stepping up or down from a start
    function automatic logic [PW-1:0] next_pick(
        input srs_pkg::srs_prof_cfg_type c [srs_pkg::NUM_PROFILES],
        input logic [PW-1:0] start,
        input logic up
    );
        logic [PW-1:0] p;
        logic found;
        p = start;
        found = 1'b0;
        for (int k = 1; k < NP; k++)
        begin
            if (!found)
            begin
                p = up ? start + PW'(k) : start - PW'(k);
                found = c[p].remote_pick_enable;
            end
        end
        return found ? p : start;
    endfunction

    // ----------------------------------------
    // Inactivity timer
    // ----------------------------------------
    wire timer_allowed = cfg.standby_in_mode[mode_q];
    wire time_zero = (cfg.standby_inactivity_time == '0);
    wire [TW-1:0] limit = (cfg.standby_inactivity_time > srs_pkg::MAX_STANDBY_S)
                          ? srs_pkg::MAX_STANDBY_S : cfg.standby_inactivity_time;
    wire tick_wrap = (tick_q == CW'(TICK - 1));
    wire expired = neutral && !time_zero && (sec_q >= limit);
    wire timeout = expired && ((state_q == srs_pkg::SRS_REMOTE) ||
                   (state_q == srs_pkg::SRS_RUN && timer_allowed));
    wire timer_clr = !neutral || (state_d != state_q);

    always_ff @(posedge i_clk or negedge i_rstn)
    begin
        if (!i_rstn)
        begin
            tick_q <= '0;
            sec_q <= '0;
        end
        else if (i_ce)
        begin
            if (timer_clr)
            begin
                tick_q <= '0;
                sec_q <= '0;
            end
            else if (!expired)
            begin
                tick_q <= tick_wrap ? '0 : tick_q + CW'(1);
                if (tick_wrap)
                    sec_q <= sec_q + TW'(1);
            end
        end
    end

    // ----------------------------------------
    // Selection state machine
    // ----------------------------------------
    wire sw_to_sby = ext_sw && cfg.external_switch_standby_enable;
    wire [PW-1:0] hl_up = next_pick(i_cfg, hl_q, 1'b1);
    wire [PW-1:0] hl_dn = next_pick(i_cfg, hl_q, 1'b0);

    always_comb
    begin
        state_d = state_q;
        mode_d = mode_q;
        prof_d = prof_q;
        hl_d = hl_q;
        case (state_q)
            srs_pkg::SRS_RUN:
            begin
                if (timeout || mode_btn || sw_to_sby)
                    state_d = srs_pkg::SRS_STANDBY;
                else if ((prof_btn || ext_sw) && cfg.remote_pick_enable)
                begin
                    state_d = srs_pkg::SRS_REMOTE;
                    hl_d = prof_q;
                end
            end
            srs_pkg::SRS_STANDBY:
            begin
                if (prof_btn || ext_sw)
                begin
                    if (cfg.remote_pick_enable)
                    begin
                        state_d = srs_pkg::SRS_REMOTE;
                        hl_d = prof_q;
                    end
                    else
                        state_d = srs_pkg::SRS_RUN;
                end
                else if (any_dir && cfg.standby_direction_pick_enable)
                begin
                    state_d = srs_pkg::SRS_RUN;
                    // One mode code per direction; fwd takes priority
                    if (dir.fwd)
                        mode_d = cfg.target_fwd;
                    else if (dir.rev)
                        mode_d = cfg.target_rev;
                    else if (dir.left)
                        mode_d = cfg.target_left;
                    else
                        mode_d = cfg.target_right;
                end
            end
            srs_pkg::SRS_REMOTE:
            begin
                if (timeout)
                    state_d = srs_pkg::SRS_STANDBY;
                else if (dir.fwd)
                begin
                    state_d = srs_pkg::SRS_RUN;
                    prof_d = hl_q;
                end
                else if (dir.right)
                    hl_d = hl_up;
                else if (dir.left)
                    hl_d = hl_dn;
            end
            default:
                state_d = srs_pkg::SRS_RUN;
        endcase
    end

    always_ff @(posedge i_clk or negedge i_rstn)
    begin
        if (!i_rstn)
        begin
            state_q <= srs_pkg::SRS_RUN;
            mode_q <= srs_pkg::RST_MODE;
            prof_q <= srs_pkg::RST_PROFILE;
            hl_q <= srs_pkg::RST_PROFILE;
        end
        else if (i_ce)
        begin
            state_q <= state_d;
            mode_q <= mode_d;
            prof_q <= prof_d;
            hl_q <= hl_d;
        end
    end

    // ----------------------------------------
    // Outputs
    // ----------------------------------------
    logic sby_q;
    logic rem_q;
    always_ff @(posedge i_clk or negedge i_rstn)
    begin
        if (!i_rstn)
        begin
            sby_q <= 1'b0;
            rem_q <= 1'b0;
        end
        else if (i_ce)
        begin
            sby_q <= (state_d == srs_pkg::SRS_STANDBY);
            rem_q <= (state_d == srs_pkg::SRS_REMOTE);
        end
    end

    assign o_mode = mode_q;
    assign o_profile = prof_q;
    assign o_highlight = hl_q;
    assign o_standby = sby_q;
    assign o_remote = rem_q;

    // ----------------------------------------
    // Assertions
    // ----------------------------------------
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (!i_rstn);

    a_fwd_target: assert property (i_ce && state_q == srs_pkg::SRS_STANDBY && dir.fwd
        && !prof_btn && !ext_sw && cfg.standby_direction_pick_enable
        |=> mode_q == $past(cfg.target_fwd) && state_q == srs_pkg::SRS_RUN)
        else $error("forward target not entered");
    a_rev_target: assert property (i_ce && state_q == srs_pkg::SRS_STANDBY && dir.rev
        && !dir.fwd && !prof_btn && !ext_sw && cfg.standby_direction_pick_enable
        |=> mode_q == $past(cfg.target_rev))
        else $error("reverse target not entered");
    a_left_target: assert property (i_ce && state_q == srs_pkg::SRS_STANDBY && dir.left
        && !dir.fwd && !dir.rev && !prof_btn && !ext_sw && cfg.standby_direction_pick_enable
        |=> mode_q == $past(cfg.target_left))
        else $error("left target not entered");
    a_right_target: assert property (i_ce && state_q == srs_pkg::SRS_STANDBY && dir.right
        && !dir.fwd && !dir.rev && !dir.left && !prof_btn && !ext_sw
        && cfg.standby_direction_pick_enable
        |=> mode_q == $past(cfg.target_right))
        else $error("right target not entered");
    a_no_pick_hold: assert property (i_ce && state_q == srs_pkg::SRS_STANDBY
        && !cfg.standby_direction_pick_enable && !prof_btn && !ext_sw
        |=> state_q == srs_pkg::SRS_STANDBY && $stable(mode_q))
        else $error("deflection acted with picking off");
    a_mode_gate: assert property (i_ce && state_q == srs_pkg::SRS_RUN && !timer_allowed
        && !mode_btn && !sw_to_sby |=> state_q != srs_pkg::SRS_STANDBY)
        else $error("standby entered in disabled mode");
    a_button_sby: assert property (i_ce && state_q == srs_pkg::SRS_RUN && mode_btn
        |=> state_q == srs_pkg::SRS_STANDBY)
        else $error("mode button ignored");
    a_remote_gate: assert property (i_ce && state_q != srs_pkg::SRS_REMOTE
        && !cfg.remote_pick_enable |=> state_q != srs_pkg::SRS_REMOTE)
        else $error("remote entered from disabled profile");
    a_remote_keep: assert property (i_ce && state_q == srs_pkg::SRS_REMOTE && timeout
        |=> state_q == srs_pkg::SRS_STANDBY && $stable(prof_q))
        else $error("remote timeout changed profile");
    a_zero_time: assert property (i_ce && time_zero && state_q != srs_pkg::SRS_STANDBY
        && !mode_btn && !sw_to_sby |=> state_q != srs_pkg::SRS_STANDBY)
        else $error("standby entered with zero time");
    a_timer_clear: assert property (i_ce && !neutral |=> sec_q == '0 && tick_q == '0)
        else $error("timer not restarted");
    a_hl_enabled: assert property (state_q == srs_pkg::SRS_REMOTE && hl_q != prof_q
        |-> i_cfg[hl_q].remote_pick_enable)
        else $error("highlighted profile not selectable");
    a_switch_gate: assert property (i_ce && state_q == srs_pkg::SRS_RUN && ext_sw
        && !timeout && !mode_btn
        && !cfg.external_switch_standby_enable |=> state_q != srs_pkg::SRS_STANDBY)
        else $error("switch entered standby while disabled");

    c_dir_pick: cover property (state_q == srs_pkg::SRS_STANDBY ##1 state_q == srs_pkg::SRS_RUN);
    c_remote: cover property (state_q == srs_pkg::SRS_REMOTE ##[1:20] prof_q != $past(prof_q));
    c_timeout: cover property (timeout && state_q == srs_pkg::SRS_RUN);
    c_rem_to: cover property (timeout && state_q == srs_pkg::SRS_REMOTE);
endmodule // srs_top

// ===== tb/srs_partner.sv
// Pin-level model of the joystick, mode button, profile button and profile switch.
// Assumes the bench changes the request vector only at the falling clock edge.
module srs_partner (
    // Requests: 0 fwd, 1 rev, 2 left, 3 right, 4 mode, 5 profile, 6 switch
    input wire logic [6:0] i_req,
    // Pins
    output logic o_js_fwd,
    output logic o_js_rev,
    output logic o_js_left,
    output logic o_js_right,
    output logic o_js_neutral,
    output logic o_mode_button,
    output logic o_profile_button,
    output logic o_ext_switch
);
    timeunit 1ns;
    timeprecision 1ps;
    assign o_js_fwd = i_req[0];
    assign o_js_rev = i_req[1];
    assign o_js_left = i_req[2];
    assign o_js_right = i_req[3];
    // Any deflection takes the stick out of the neutral area
    assign o_js_neutral = ~|i_req[3:0];
    assign o_mode_button = i_req[4];
    assign o_profile_button = i_req[5];
    assign o_ext_switch = i_req[6];
endmodule // srs_partner

// ===== tb/srs_top_tb.sv
// Self-checking bench for the standby and remote selection block.
// Assumes a short second tick so inactivity timeouts take tens of cycles.
module srs_top_tb;
    timeunit 1ns;
    timeprecision 1ps;
    // ----------------------------------------
    // Signals
    // ----------------------------------------
    localparam int TICK = 10;
    localparam int LIMIT = 3000;
    logic i_clk = 1'b0;
    logic i_rstn = 1'b0;
    logic ce = 1'b1;
    logic [6:0] req = 7'h00;
    logic fwd, rev, left, right, neutral, mode_b, prof_b, ext_s;
    srs_pkg::srs_prof_cfg_type cfg [srs_pkg::NUM_PROFILES];
    logic [2:0] o_mode, o_profile, o_highlight;
    logic o_standby, o_remote;
    int bad_count = 0;
    int checked = 0;
    int cyc = 0;
    typedef struct {logic [6:0] dir; logic [2:0] mode;} srs_row_type;
    srs_row_type rows [4] = '{'{7'h01, 3'h1}, '{7'h02, 3'h2}, '{7'h04, 3'h3}, '{7'h08, 3'h4}};
    always #20 i_clk = ~i_clk;
    srs_partner far_side (.i_req(req), .o_js_fwd(fwd), .o_js_rev(rev), .o_js_left(left),
        .o_js_right(right), .o_js_neutral(neutral), .o_mode_button(mode_b),
        .o_profile_button(prof_b), .o_ext_switch(ext_s));
    srs_top #(.TICK(TICK)) dut (.i_clk(i_clk), .i_rstn(i_rstn), .i_ce(ce),
        .i_js_fwd(fwd), .i_js_rev(rev), .i_js_left(left), .i_js_right(right),
        .i_js_neutral(neutral), .i_mode_button(mode_b), .i_profile_button(prof_b),
        .i_ext_switch(ext_s), .i_cfg(cfg), .o_mode(o_mode), .o_profile(o_profile),
        .o_standby(o_standby), .o_remote(o_remote), .o_highlight(o_highlight));
    // ----------------------------------------
    // Tasks
    // ----------------------------------------
    task automatic tally_and_finish();
        $display("Checks %0d, mismatches %0d", checked, bad_count);
        if (bad_count == 0 && checked > 0)
        begin
            $display("All tests passed");
        end
        else
        begin
            $display("Some tests failed");
        end
        $finish;
    endtask
    // Holds a request long enough to pass the synchronisers, then releases it
    task automatic press(input logic [6:0] bits);
        @(negedge i_clk);
        req = bits;
        repeat (4) @(negedge i_clk);
        req = 7'h00;
        repeat (6) @(negedge i_clk);
    endtask
    task automatic idle(input int n);
        repeat (n) @(negedge i_clk);
    endtask
    // Highlight bit 3 set means the highlight is not compared
    task automatic expect_st(input logic sb, input logic rm, input logic [2:0] md,
        input logic [2:0] pf, input logic [3:0] hl);
        checked++;
        if ({o_standby, o_remote, o_mode, o_profile} !== {sb, rm, md, pf}
            || (!hl[3] && o_highlight !== hl[2:0]))
        begin
            bad_count++;
            $display("MISMATCH at %0t: sb %b rm %b mode %h prof %h hl %h", $time,
                o_standby, o_remote, o_mode, o_profile, o_highlight);
        end
    endtask
    // ----------------------------------------
    // Timeout
    // ----------------------------------------
    always @(posedge i_clk)
    begin
        cyc <= cyc + 1;
        if (cyc == LIMIT)
        begin
            bad_count++;
            $display("MISMATCH at %0t: run did not finish", $time);
            tally_and_finish();
        end
    end
    // ----------------------------------------
    // Main sequence
    // ----------------------------------------
    initial
    begin
        for (int p = 0; p < srs_pkg::NUM_PROFILES; p++)
        begin
            cfg[p] = '{8'hff, 8'h02, 1'b0, 1'b1, 1'b0, 3'h1, 3'h2, 3'h3, 3'h4};
        end
        cfg[0].standby_in_mode = 8'hef;
        cfg[0].remote_pick_enable = 1'b1;
        cfg[2] = '{8'hff, 8'h00, 1'b1, 1'b0, 1'b1, 3'h1, 3'h2, 3'h3, 3'h4};
        cfg[5].remote_pick_enable = 1'b1;
        idle(2);
        i_rstn = 1'b1;
        idle(1);
        expect_st(1'b0, 1'b0, 3'h0, 3'h0, 4'h0);
        $display("Test reset done");
        foreach (rows[i])
        begin
            press(7'h10);
            expect_st(1'b1, 1'b0, (i == 0) ? 3'h0 : rows[i - 1].mode, 3'h0, 4'h8);
            press(rows[i].dir);
            expect_st(1'b0, 1'b0, rows[i].mode, 3'h0, 4'h8);
        end
        $display("Test direction table done");
        idle(60);
        expect_st(1'b0, 1'b0, 3'h4, 3'h0, 4'h8);
        press(7'h10);
        expect_st(1'b1, 1'b0, 3'h4, 3'h0, 4'h8);
        press(7'h01);
        @(negedge i_clk);
        req = 7'h01;
        idle(60);
        expect_st(1'b0, 1'b0, 3'h1, 3'h0, 4'h8);
        req = 7'h00;
        idle(60);
        expect_st(1'b1, 1'b0, 3'h1, 3'h0, 4'h8);
        $display("Test inactivity done");
        press(7'h20);
        expect_st(1'b0, 1'b1, 3'h1, 3'h0, 4'h0);
        press(7'h08);
        expect_st(1'b0, 1'b1, 3'h1, 3'h0, 4'h2);
        press(7'h08);
        expect_st(1'b0, 1'b1, 3'h1, 3'h0, 4'h5);
        press(7'h08);
        expect_st(1'b0, 1'b1, 3'h1, 3'h0, 4'h0);
        press(7'h04);
        expect_st(1'b0, 1'b1, 3'h1, 3'h0, 4'h5);
        idle(60);
        expect_st(1'b1, 1'b0, 3'h1, 3'h0, 4'h8);
        $display("Test remote timeout done");
        press(7'h20);
        press(7'h08);
        press(7'h01);
        expect_st(1'b0, 1'b0, 3'h1, 3'h2, 4'h8);
        idle(60);
        expect_st(1'b0, 1'b0, 3'h1, 3'h2, 4'h8);
        press(7'h40);
        expect_st(1'b1, 1'b0, 3'h1, 3'h2, 4'h8);
        press(7'h01);
        expect_st(1'b1, 1'b0, 3'h1, 3'h2, 4'h8);
        press(7'h20);
        expect_st(1'b0, 1'b1, 3'h1, 3'h2, 4'h2);
        press(7'h08);
        press(7'h01);
        expect_st(1'b0, 1'b0, 3'h1, 3'h5, 4'h8);
        press(7'h40);
        expect_st(1'b0, 1'b1, 3'h1, 3'h5, 4'h5);
        press(7'h01);
        expect_st(1'b0, 1'b0, 3'h1, 3'h5, 4'h8);
        $display("Test switch and pick done");
        // A mode button press while the clock enable is low must leave no trace
        ce = 1'b0;
        press(7'h10);
        ce = 1'b1;
        idle(2);
        expect_st(1'b0, 1'b0, 3'h1, 3'h5, 4'h8);
        $display("Test clock enable done");
        // Profile button held through a mid-run reset must not count as a press
        req = 7'h20;
        i_rstn = 1'b0;
        idle(2);
        i_rstn = 1'b1;
        idle(6);
        expect_st(1'b0, 1'b0, 3'h0, 3'h0, 4'h0);
        req = 7'h00;
        idle(4);
        expect_st(1'b0, 1'b0, 3'h0, 3'h0, 4'h0);
        $display("Test mid-run reset done");
        tally_and_finish();
    end
endmodule // srs_top_tb
